// ==== dv/mct_timebase_chk.sv ====
// Purpose: Port assertions for the clock and time-base controller.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound from the testbench top file.
`timescale 1ns/10ps
module mct_timebase_chk
  import mct_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic cpuIrqMask,
  input wire logic waitReq,
  input wire logic haltReq,
  input wire logic otherHaltWake,
  input wire logic [1:0] powerState,
  input wire logic wakeup,
  input wire logic timebaseIrq,
  input wire logic cpuClkEn,
  input wire logic clockOutputEn
);
  // ****************************************
  // Port checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not OKAY");
  a_rd_phase: assert property (hrdata != 32'h0 |-> $past(hsel && htrans == 2'h2 && !hwrite))
    else $error("read data outside a read data phase");
  a_irq_mask: assert property (timebaseIrq |-> !$past(cpuIrqMask))
    else $error("interrupt raised while masked");
  a_clkout_off: assert property (powerState == 2'h2 |-> !clockOutputEn)
    else $error("clock output active in active halt");
  a_halt_noclk: assert property (powerState[1] && $past(powerState[1]) |-> !cpuClkEn)
    else $error("cpu clock runs in a halt state");
  a_halt_stays: assert property (powerState == 2'h3 && !otherHaltWake |=> powerState == 2'h3)
    else $error("halt left without a halt wake source");
  a_halt_entry: assert property (powerState == 2'h0 && haltReq |=> powerState[1])
    else $error("halt request not taken");
  a_wake_pulse: assert property (wakeup |-> powerState == 2'h0 && $past(powerState) != 2'h0)
    else $error("wake pulse without leaving low power");
  a_run_hold: assert property (powerState == 2'h0 && !haltReq && !waitReq |=> powerState == 2'h0)
    else $error("run state left without request");
  c_irq: cover property (timebaseIrq);
  c_ahalt: cover property (powerState == 2'h2);
  c_wake: cover property (wakeup);
endmodule

// ==== dv/mct_timebase_tb.sv ====
// Purpose: Self-checking bench for the clock and time-base controller.
// Assumes: Short periods stand in for the long counts.
// Notes: Bus tasks issue single AHB-Lite word transfers.
`timescale 1ns/10ps
module mct_timebase_tb
  import mct_pkg::*;
  ;
  localparam int PER[4] = '{20, 40, 60, 80};
  logic clk = 1'h0, rst_n = 1'h0, hsel = 1'h0, hwrite = 1'h0, cpuIrqMask = 1'h0;
  logic waitReq = 1'h0, haltReq = 1'h0, otherHaltWake = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdv;
  logic hreadyout, hresp, wakeup, timebaseIrq, cpuClkEn, clockOutputPin, clockOutputEn;
  logic [1:0] powerState;
  int n_fail = 0, cmp_count = 0, g = 0;
  time tLast = 0;
  always #20 clk = ~clk;
  mct_timebase #(.PERIOD0(PER[0]), .PERIOD1(PER[1]), .PERIOD2(PER[2]), .PERIOD3(PER[3])) dut_u (
    .clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(MCT_HSIZE_WORD), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .cpuIrqMask, .waitReq, .haltReq,
    .otherHaltWake, .powerState, .wakeup, .timebaseIrq, .cpuClkEn, .clockOutputPin,
    .clockOutputEn);
  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= MCT_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= a;
    do @(posedge clk); while (hreadyout !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'h1);
    rdv = hrdata;
  endtask
  task automatic gap();
    int k;
    k = 0;
    while (timebaseIrq !== 1'h1 && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    g = int'(($time - tLast) / 40);
    tLast = $time;
    bus(1'h0, MCT_CSR_ADDR, 32'h0);
    chk("flag", 32'h1, 32'(rdv[0]));
    bus(1'h0, MCT_CSR_ADDR, 32'h0);
    chk("flag clear", 32'h0, 32'(rdv[0]));
    @(posedge clk);
  endtask
  task automatic wait_run();
    int k;
    k = 0;
    while (powerState !== 2'h0 && k < 300)
    begin
      @(posedge clk);
      k++;
    end
    chk("wake", 32'h0, 32'(powerState));
  endtask
  task automatic t_regs();
    bus(1'h0, MCT_CSR_ADDR, 32'h0);
    chk("reset", {24'h0, MCT_CSR_RESET}, rdv);
    bus(1'h1, MCT_CSR_ADDR, 32'hFE);
    bus(1'h1, 32'h4, 32'h0);
    bus(1'h0, MCT_CSR_ADDR, 32'h0);
    chk("csr", 32'hFE, {rdv[31:1], 1'h0});
    bus(1'h0, 32'h4, 32'h0);
    chk("unmapped", 32'h0, rdv);
    bus(1'h1, MCT_CSR_ADDR, 32'h0);
  endtask
  task automatic t_slow();
    int c;
    for (int p = 0; p < 5; p++)
    begin
      bus(1'h1, MCT_CSR_ADDR, (p < 4) ? 32'(16 + p * 32) : 32'h0);
      repeat (20) @(posedge clk);
      c = 0;
      repeat (64)
      begin
        @(posedge clk);
        c += int'(cpuClkEn === 1'h1);
      end
      chk("cpu clock", (p < 4) ? 32'(32 >> p) : 32'h40, 32'(c));
    end
  endtask
  task automatic t_period();
    bus(1'h1, MCT_CSR_ADDR, 32'h2);
    gap();
    gap();
    for (int i = 1; i < 4; i++)
    begin
      bus(1'h1, MCT_CSR_ADDR, 32'(i * 4 + 2));
      gap();
      chk("old period", 32'(PER[i - 1]), 32'(g));
      gap();
      chk("new period", 32'(PER[i]), 32'(g));
    end
  endtask
  task automatic t_mask();
    cpuIrqMask <= 1'h1;
    bus(1'h1, MCT_CSR_ADDR, 32'h2);
    repeat (100) @(posedge clk);
    chk("masked irq", 32'h0, 32'(timebaseIrq));
    bus(1'h0, MCT_CSR_ADDR, 32'h0);
    chk("masked flag", 32'h1, 32'(rdv[0]));
    cpuIrqMask <= 1'h0;
  endtask
  task automatic t_power();
    bus(1'h1, MCT_CSR_ADDR, 32'h82);
    gap();
    repeat (3) @(posedge clk);
    chk("clock out", 32'h1, 32'(clockOutputEn));
    haltReq <= 1'h1;
    @(posedge clk);
    haltReq <= 1'h0;
    repeat (2) @(posedge clk);
    chk("active halt", 32'h2, 32'(powerState));
    chk("clock out off", 32'h0, 32'(clockOutputEn));
    bus(1'h1, MCT_CSR_ADDR, 32'h0);
    wait_run();
    bus(1'h0, MCT_CSR_ADDR, 32'h0);
    chk("frozen csr", 32'h82, {rdv[31:1], 1'h0});
    bus(1'h1, MCT_CSR_ADDR, 32'h0);
    haltReq <= 1'h1;
    @(posedge clk);
    haltReq <= 1'h0;
    repeat (60) @(posedge clk);
    chk("halt held", 32'h3, 32'(powerState));
    otherHaltWake <= 1'h1;
    @(posedge clk);
    otherHaltWake <= 1'h0;
    wait_run();
    bus(1'h1, MCT_CSR_ADDR, 32'h2);
    waitReq <= 1'h1;
    @(posedge clk);
    waitReq <= 1'h0;
    repeat (2) @(posedge clk);
    chk("wait", 32'h1, 32'(powerState));
    wait_run();
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    t_regs();
    t_slow();
    t_period();
    t_mask();
    t_power();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    final_report();
  end
endmodule
bind mct_timebase mct_timebase_chk chk_u (.clk, .rst_n, .hsel, .htrans, .hwrite, .hrdata,
  .hreadyout, .hresp, .cpuIrqMask, .waitReq, .haltReq, .otherHaltWake, .powerState,
  .wakeup, .timebaseIrq, .cpuClkEn, .clockOutputEn);

// ==== verilog/mct_ahb_slave.sv ====
// Purpose: AHB-Lite slave decoding the single control/status word.
// Assumes: Only whole-word single transfers; response always OKAY.
// Notes: Zero wait states; read data is captured in a flip-flop at the address phase.
`timescale 1ns/10ps
module mct_ahb_slave
  import mct_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  mct_bus_if.slave bus
);
  typedef struct packed
  {
    logic wrPend;
    logic [31:0] rdWord;
  } mct_ahbst_t;

  mct_ahbst_t st_r;
  mct_ahbst_t st_nxt;
  logic hit;

  assign hit = hsel && hready && htrans == MCT_HTRANS_NONSEQ && hsize == MCT_HSIZE_WORD &&
               haddr == MCT_CSR_ADDR;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.wrPend = hit && hwrite;
    st_nxt.rdWord = (hit && !hwrite) ? {24'h000000, bus.rdData} : 32'h0000_0000;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Unmapped addresses read zero. The read strobe fires in the address phase, at the
  // same edge that captures the word, so a flag set in that cycle survives to the next read.
  assign hrdata = st_r.rdWord;
  assign bus.wrStb = st_r.wrPend;
  assign bus.rdStb = hit && !hwrite;
  assign bus.wrData = hwdata[7:0];
endmodule

// ==== verilog/mct_bus_if.sv ====
// Purpose: Carries decoded register accesses from the bus slave to the core.
// Assumes: Single clock.
// Notes: Strobes are one-cycle pulses.
`timescale 1ns/10ps
interface mct_bus_if;
  logic wrStb;
  logic rdStb;
  logic [7:0] wrData;
  logic [7:0] rdData;
  modport slave (output wrStb, output rdStb, output wrData, input rdData);
  modport core (input wrStb, input rdStb, input wrData, output rdData);
endinterface

// ==== verilog/mct_pkg.sv ====
// Purpose: Shared constants and types for the main clock and time-base controller.
// Assumes: One system clock serves as the oscillator clock.
// Notes: Register occupies one aligned AHB-Lite word.
package mct_pkg;
  localparam logic [31:0] MCT_CSR_ADDR = 32'h0000_0000;
  localparam logic [7:0] MCT_CSR_RESET = 8'h00;
  localparam int MCT_BIT_CLKOUT = 7;
  localparam int MCT_BIT_PRE_HI = 6;
  localparam int MCT_BIT_PRE_LO = 5;
  localparam int MCT_BIT_SLOW = 4;
  localparam int MCT_BIT_TB_HI = 3;
  localparam int MCT_BIT_TB_LO = 2;
  localparam int MCT_BIT_IRQEN = 1;
  localparam int MCT_BIT_OVF = 0;
  localparam int MCT_PERIOD0 = 16000;
  localparam int MCT_PERIOD1 = 32000;
  localparam int MCT_PERIOD2 = 80000;
  localparam int MCT_PERIOD3 = 200000;
  localparam int MCT_CNT_W = 18;
  localparam int MCT_PRE_W = 4;
  localparam logic [1:0] MCT_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] MCT_HSIZE_WORD = 3'h2;

  typedef enum logic [1:0]
  {
    MCT_RUN = 2'b00,
    MCT_WAIT = 2'b01,
    MCT_ACTHALT = 2'b10,
    MCT_HALT = 2'b11
  } mct_pwr_t;
endpackage

// ==== verilog/mct_timebase.sv ====
// Purpose: Main clock controller with time base, register and wake logic.
// Assumes: clk is the oscillator clock; power mode and interrupt mask come from the CPU.
// Notes: The CPU clock is given as a one-cycle enable plus a pin-level square wave.
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module mct_timebase
  import mct_pkg::*;
#(
  parameter int PERIOD0 = MCT_PERIOD0,
  parameter int PERIOD1 = MCT_PERIOD1,
  parameter int PERIOD2 = MCT_PERIOD2,
  parameter int PERIOD3 = MCT_PERIOD3
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic cpuIrqMask,
  input wire logic waitReq,
  input wire logic haltReq,
  input wire logic otherHaltWake,
  output logic [1:0] powerState,
  output logic wakeup,
  output logic timebaseIrq,
  output logic cpuClkEn,
  output logic clockOutputPin,
  output logic clockOutputEn
);
  // Periods must fit the counter and leave room for a terminal count.
  if (PERIOD0 < 2 || PERIOD1 < 2 || PERIOD2 < 2 || PERIOD3 < 2 ||
      PERIOD3 >= (1 << MCT_CNT_W) || PERIOD2 >= (1 << MCT_CNT_W) ||
      PERIOD1 >= (1 << MCT_CNT_W) || PERIOD0 >= (1 << MCT_CNT_W))
  begin : g_bad_period
    $error("mct_timebase: period parameter out of range");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic [7:0] csr;
    logic [1:0] tbActive;
    logic [MCT_CNT_W-1:0] tbCnt;
    logic [MCT_PRE_W-1:0] preCnt;
    mct_pwr_t pwr;
    logic irq;
    logic wake;
    logic cpuEn;
    logic pinLvl;
    logic pinEn;
    logic [1:0] pwrOut;
  } mct_core_t;

  mct_core_t st_r;
  mct_core_t st_nxt;
  mct_bus_if bus ();

  mct_ahb_slave u_slave
  (
    .clk(clk),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata(hrdata),
    .bus(bus)
  );

  assign bus.rdData = st_r.csr;

  function automatic logic [MCT_CNT_W-1:0] periodLast(input logic [1:0] sel);
    case (sel)
      2'h0: periodLast = MCT_CNT_W'(PERIOD0 - 1);
      2'h1: periodLast = MCT_CNT_W'(PERIOD1 - 1);
      2'h2: periodLast = MCT_CNT_W'(PERIOD2 - 1);
      default: periodLast = MCT_CNT_W'(PERIOD3 - 1);
    endcase
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic tbRun;
  logic tbEnd;
  logic regsLive;
  logic [MCT_PRE_W-1:0] preLast;
  logic preEnd;
  logic ovfEvent;

  always_comb
  begin
    st_nxt = st_r;
    tbRun = st_r.pwr != MCT_HALT;
    regsLive = st_r.pwr == MCT_RUN || st_r.pwr == MCT_WAIT;
    tbEnd = tbRun && st_r.tbCnt == periodLast(st_r.tbActive);
    ovfEvent = tbEnd;
    // Divide-by-2^(n+1) terminal count for the slow-mode prescaler.
    preLast = MCT_PRE_W'((2 << st_r.csr[MCT_BIT_PRE_HI:MCT_BIT_PRE_LO]) - 1);
    preEnd = st_r.preCnt >= preLast;

    if (tbRun)
    begin
      if (tbEnd)
      begin
        st_nxt.tbCnt = '0;
        st_nxt.tbActive = st_r.csr[MCT_BIT_TB_HI:MCT_BIT_TB_LO];
      end
      else
        st_nxt.tbCnt = st_r.tbCnt + 1'b1;
    end

    if (regsLive)
    begin
      if (bus.rdStb)
        st_nxt.csr[MCT_BIT_OVF] = 1'b0;
      if (bus.wrStb)
        st_nxt.csr[7:1] = bus.wrData[7:1];
    end
    if (ovfEvent)
      st_nxt.csr[MCT_BIT_OVF] = 1'b1;

    // Slow mode pulses the CPU enable once per prescaler period.
    if (st_r.pwr == MCT_HALT || st_r.pwr == MCT_ACTHALT)
      st_nxt.cpuEn = 1'b0;
    else if (!st_r.csr[MCT_BIT_SLOW])
    begin
      st_nxt.cpuEn = 1'b1;
      st_nxt.preCnt = '0;
    end
    else
    begin
      st_nxt.preCnt = preEnd ? '0 : st_r.preCnt + 1'b1;
      st_nxt.cpuEn = preEnd;
    end

    st_nxt.irq = st_nxt.csr[MCT_BIT_OVF] && st_nxt.csr[MCT_BIT_IRQEN] && !cpuIrqMask;
    st_nxt.wake = 1'b0;

    case (st_r.pwr)
      MCT_RUN:
      begin
        if (haltReq)
          st_nxt.pwr = st_r.csr[MCT_BIT_IRQEN] ? MCT_ACTHALT : MCT_HALT;
        else if (waitReq)
          st_nxt.pwr = MCT_WAIT;
      end
      MCT_WAIT:
      begin
        if (ovfEvent && st_r.csr[MCT_BIT_IRQEN] || otherHaltWake)
        begin
          st_nxt.pwr = MCT_RUN;
          st_nxt.wake = 1'b1;
        end
      end
      MCT_ACTHALT:
      begin
        if (ovfEvent && st_r.csr[MCT_BIT_IRQEN] || otherHaltWake)
        begin
          st_nxt.pwr = MCT_RUN;
          st_nxt.wake = 1'b1;
        end
      end
      MCT_HALT:
      begin
        if (otherHaltWake)
        begin
          st_nxt.pwr = MCT_RUN;
          st_nxt.wake = 1'b1;
        end
      end
      default: st_nxt.pwr = MCT_RUN;
    endcase
    st_nxt.pwrOut = st_nxt.pwr;

    // Gating on the next power state keeps the pin quiet from the first active-halt cycle.
    st_nxt.pinEn = st_r.csr[MCT_BIT_CLKOUT] && st_nxt.pwr != MCT_ACTHALT;
    if (!st_nxt.pinEn)
      st_nxt.pinLvl = 1'b0;
    else if (!st_r.csr[MCT_BIT_SLOW])
      st_nxt.pinLvl = !st_r.pinLvl;
    else
      st_nxt.pinLvl = st_r.preCnt < (preLast >> 1) + 1'b1 ? 1'b1 : 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
      st_r.csr <= MCT_CSR_RESET;
      st_r.pwr <= MCT_RUN;
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign powerState = st_r.pwrOut;
  assign wakeup = st_r.wake;
  assign timebaseIrq = st_r.irq;
  assign cpuClkEn = st_r.cpuEn;
  assign clockOutputPin = st_r.pinLvl;
  assign clockOutputEn = st_r.pinEn;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule
